// *** logic/bod_pkg.sv ***
`default_nettype none

package bod_pkg;

	// ==========================================================
	// Opcodes handled by the decoder.
	localparam logic [7:0] OP_JUMP_NO_OVERFLOW = 8'h71;
	localparam logic [7:0] OP_JUMP_EQUAL = 8'h74;
	localparam logic [7:0] OP_JUMP_NOT_EQUAL = 8'h75;
	localparam logic [7:0] OP_LOOP_COUNT = 8'he2;
	localparam logic [7:0] OP_LOOP_WHILE_EQUAL = 8'he1;
	localparam logic [7:0] OP_LEAVE_PROC = 8'hc9;
	localparam logic [7:0] OP_INT_ON_OVERFLOW = 8'hce;
	localparam logic [7:0] OP_INTERRUPT_RETURN = 8'hcf;
	localparam logic [7:0] OP_BUS_LOCK = 8'hf0;
	localparam logic [4:0] OP_EXT_ESCAPE_TOP = 5'h1b;
	localparam logic [2:0] OP_SEG_PREFIX_TOP = 3'h1;
	localparam logic [2:0] OP_SEG_PREFIX_LOW = 3'h6;

	// ==========================================================
	// Clock costs, reported as cycle counts.
	localparam logic [5:0] CLK_JCC_FALL = 6'h04;
	localparam logic [5:0] CLK_JCC_TAKEN = 6'h0d;
	localparam logic [5:0] CLK_LOOP_FALL = 6'h05;
	localparam logic [5:0] CLK_LOOP_TAKEN = 6'h0f;
	localparam logic [5:0] CLK_LOOP_WHILE_EQUAL_FALL = 6'h06;
	localparam logic [5:0] CLK_LOOP_WHILE_EQUAL_TAKEN = 6'h10;
	localparam logic [5:0] CLK_LEAVE = 6'h08;
	localparam logic [5:0] CLK_INTO_TAKEN = 6'h30;
	localparam logic [5:0] CLK_INTO_FALL = 6'h04;
	localparam logic [5:0] CLK_INTERRUPT_RETURN_OP = 6'h1c;
	localparam logic [5:0] CLK_LOCK = 6'h02;
	localparam logic [5:0] CLK_ESCAPE = 6'h06;

	// ==========================================================
	// Addressing byte fields, segment codes and stack pop counts.
	localparam logic [1:0] MOD_NO_DISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REGISTER = 2'h3;
	localparam logic [2:0] RM_DIRECT = 3'h6;
	localparam int MODRM_MOD_POS = 6;
	localparam int MODRM_REG_POS = 3;
	localparam logic [1:0] SEG_EXTRA = 2'h0;
	localparam logic [1:0] SEG_CODE = 2'h1;
	localparam logic [1:0] SEG_STACK = 2'h2;
	localparam logic [1:0] SEG_DATA = 2'h3;
	localparam logic [1:0] POP_LEAVE = 2'h1;
	localparam logic [1:0] POP_INTERRUPT_RETURN_OP = 2'h3;

	typedef enum logic [3:0] {
		CLS_NONE = 4'h0, CLS_JCC = 4'h1, CLS_LOOP = 4'h2, CLS_LEAVE = 4'h3,
		CLS_INTO = 4'h4, CLS_INTERRUPT_RETURN_OP = 4'h5, CLS_LOCK = 4'h6, CLS_ESCAPE = 4'h7,
		CLS_OTHER = 4'h8
	} bod_class_t;

	typedef enum logic [2:0] {
		ST_OPCODE = 3'h0, ST_MODRM = 3'h1, ST_DISP_LO = 3'h3, ST_DISP_HI = 3'h2,
		ST_FINISH = 3'h6
	} bod_state_t;

endpackage

`default_nettype wire

// *** logic/bod_decoder.sv ***
`default_nettype none

// Behaviour
// RULE_01 - no-overflow jump costs 4 or 13
// RULE_02 - not-equal jump branches on zero clear
// RULE_03 - equal jump branches on zero set
// RULE_04 - count loop decrements, branches while nonzero
// RULE_05 - loop-while-equal needs nonzero count and zero
// RULE_06 - leave reloads stack pointer, pops frame
// RULE_07 - overflow interrupt only when overflow set
// RULE_08 - interrupt return pops three words, 28
// RULE_09 - lock prefix holds lock over next instruction
// RULE_10 - escape hands opcode fields and operand out
// RULE_11 - mod 11 makes r/m a register
// RULE_12 - mod 00 means zero displacement
// RULE_13 - mod 01 fetches one sign-extended byte
// RULE_14 - mod 10 fetches two bytes, low first
// RULE_15 - r/m picks base and index sum
// RULE_16 - mod 00 r/m 110 is direct address
// RULE_17 - displacement follows addressing byte, before immediates
// RULE_18 - segment field codes extra, code, stack, data
// RULE_19 - register field decoding by width bit
// RULE_20 - frame pointer operands use stack segment
// RULE_21 - string destinations always use extra segment
// RULE_22 - short branch adds signed byte to next address
module bod_decoder (
	input wire logic clk_sys, // 20 MHz core clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic byte_valid, // instruction byte offered
	input wire logic [7:0] byte_data, // instruction byte
	input wire logic [15:0] byte_ip, // address of the offered byte
	input wire logic flag_zero, // zero flag
	input wire logic flag_overflow, // overflow flag
	input wire logic [15:0] base_word_reg, // base register value
	input wire logic [15:0] frame_pointer_reg, // frame pointer value
	input wire logic [15:0] source_index_reg, // source index value
	input wire logic [15:0] destination_index_reg, // destination index value
	input wire logic [15:0] count_reg, // count register value
	input wire logic string_dest_access, // operand is a string destination
	output logic byte_ready, // decoder takes a byte this cycle
	output logic done, // one-cycle pulse, results valid
	output logic [3:0] op_class, // class of decoded instruction
	output logic [7:0] op_code, // decoded opcode
	output logic [5:0] op_clocks, // clock cost of the instruction
	output logic branch_taken, // control transfer taken
	output logic [15:0] branch_target, // short branch target
	output logic [15:0] count_next, // decremented count register
	output logic count_write, // count register takes count_next
	output logic sp_load_frame, // stack pointer reloads from frame pointer
	output logic [1:0] stack_pops, // words popped from the stack
	output logic int_request, // software interrupt raised
	output logic lock_active, // bus lock held
	output logic ext_valid, // escape word for the extension
	output logic [5:0] ext_opcode, // escape opcode fields
	output logic operand_is_reg, // r/m names a register
	output logic ea_valid, // effective address is valid
	output logic [15:0] effective_address, // operand offset
	output logic [1:0] ea_segment, // segment used for the operand
	output logic [2:0] reg_index, // reg field register number
	output logic reg_high_byte, // reg field names a high byte
	output logic [2:0] rm_index, // r/m field register number
	output logic rm_high_byte // r/m field names a high byte
);

	// ==========================================================
	// Register field decoding.
	// Byte registers 100..111 are the high halves of the first four words.
	function automatic logic [3:0] reg_decode(input logic [2:0] field, input logic wide);
		reg_decode = wide ? {1'b0, field} : {field[2], 1'b0, field[1:0]}; // RULE_19
	endfunction

	// ==========================================================
	// State and captured bytes.
	bod_pkg::bod_state_t state_r, state_nxt;
	logic [7:0] op_r, modrm_r;
	logic [15:0] disp_r, next_ip_r;
	logic lock_pend_r, ovr_valid_r, ready_r;
	logic [1:0] ovr_seg_r;

	wire take = byte_valid && ready_r;
	wire is_seg_prefix = byte_data[7:5] == bod_pkg::OP_SEG_PREFIX_TOP
		&& byte_data[2:0] == bod_pkg::OP_SEG_PREFIX_LOW;
	wire is_escape = byte_data[7:3] == bod_pkg::OP_EXT_ESCAPE_TOP;
	wire is_short = byte_data == bod_pkg::OP_JUMP_NO_OVERFLOW
		|| byte_data == bod_pkg::OP_JUMP_EQUAL || byte_data == bod_pkg::OP_JUMP_NOT_EQUAL
		|| byte_data == bod_pkg::OP_LOOP_COUNT || byte_data == bod_pkg::OP_LOOP_WHILE_EQUAL;
	wire [1:0] in_mod = byte_data[7:6];
	wire [2:0] in_rm = byte_data[2:0];
	wire [1:0] mod_f = modrm_r[bod_pkg::MODRM_MOD_POS +: 2];
	wire [2:0] reg_f = modrm_r[bod_pkg::MODRM_REG_POS +: 3];
	wire [2:0] rm_f = modrm_r[2:0];
	wire op_short = op_r == bod_pkg::OP_JUMP_NO_OVERFLOW || op_r == bod_pkg::OP_JUMP_EQUAL
		|| op_r == bod_pkg::OP_JUMP_NOT_EQUAL || op_r == bod_pkg::OP_LOOP_COUNT
		|| op_r == bod_pkg::OP_LOOP_WHILE_EQUAL;
	wire op_escape = op_r[7:3] == bod_pkg::OP_EXT_ESCAPE_TOP;
	wire modrm_only = in_mod == bod_pkg::MOD_REGISTER
		|| (in_mod == bod_pkg::MOD_NO_DISP && in_rm != bod_pkg::RM_DIRECT);
	wire disp_last = op_short || mod_f == bod_pkg::MOD_DISP8;

	// ==========================================================
	// Sequencer. The addressing byte comes right after the opcode and the
	// displacement right after it, so immediates never split a displacement.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bod_pkg::ST_OPCODE: begin
				if (take && !is_seg_prefix)
					state_nxt = is_short ? bod_pkg::ST_DISP_LO
						: is_escape ? bod_pkg::ST_MODRM : bod_pkg::ST_FINISH;
			end
			bod_pkg::ST_MODRM: begin
				if (take) // RULE_11 RULE_12 RULE_16 RULE_17
					state_nxt = modrm_only ? bod_pkg::ST_FINISH : bod_pkg::ST_DISP_LO;
			end
			bod_pkg::ST_DISP_LO: begin
				if (take) // RULE_13 RULE_14
					state_nxt = disp_last ? bod_pkg::ST_FINISH : bod_pkg::ST_DISP_HI;
			end
			bod_pkg::ST_DISP_HI: state_nxt = take ? bod_pkg::ST_FINISH : state_r;
			default: state_nxt = bod_pkg::ST_OPCODE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= bod_pkg::ST_OPCODE;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ready_r <= state_nxt != bod_pkg::ST_FINISH;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			op_r <= 8'h00;
			modrm_r <= 8'h00;
			disp_r <= 16'h0000;
			next_ip_r <= 16'h0000;
		end else begin
			if (take)
				next_ip_r <= 16'(byte_ip + 16'h0001);
			if (take && state_r == bod_pkg::ST_OPCODE && !is_seg_prefix) begin
				op_r <= byte_data;
				modrm_r <= 8'h00;
				disp_r <= 16'h0000;
			end
			if (take && state_r == bod_pkg::ST_MODRM)
				modrm_r <= byte_data;
			if (take && state_r == bod_pkg::ST_DISP_LO)
				disp_r <= {{8{byte_data[7]}}, byte_data}; // RULE_13
			if (take && state_r == bod_pkg::ST_DISP_HI)
				disp_r[15:8] <= byte_data; // RULE_14
		end
	end

	// ==========================================================
	// Prefixes. A lock or override survives until the next real
	// instruction finishes.
	wire fin = state_r == bod_pkg::ST_FINISH;
	wire fin_lock = fin && op_r == bod_pkg::OP_BUS_LOCK;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lock_pend_r <= 1'b0;
			ovr_valid_r <= 1'b0;
			ovr_seg_r <= bod_pkg::SEG_DATA;
		end else begin
			if (fin)
				lock_pend_r <= fin_lock; // RULE_09
			if (take && state_r == bod_pkg::ST_OPCODE && is_seg_prefix) begin
				ovr_valid_r <= 1'b1;
				ovr_seg_r <= byte_data[4:3]; // RULE_18
			end else if (fin && !fin_lock)
				ovr_valid_r <= 1'b0;
		end
	end

	// ==========================================================
	// Branch conditions and costs.
	wire [15:0] cnt_dec = 16'(count_reg - 16'h0001);
	wire cnt_nz = cnt_dec != 16'h0000;
	wire jcc_taken = op_r == bod_pkg::OP_JUMP_NO_OVERFLOW ? !flag_overflow // RULE_01
		: op_r == bod_pkg::OP_JUMP_EQUAL ? flag_zero : !flag_zero; // RULE_02 RULE_03
	wire loop_taken = cnt_nz && (op_r == bod_pkg::OP_LOOP_COUNT || flag_zero); // RULE_04 RULE_05
	wire [15:0] short_target = 16'(next_ip_r + disp_r); // RULE_22
	logic taken_c;
	logic [5:0] clocks_c;
	bod_pkg::bod_class_t class_c;

	always_comb begin
		taken_c = 1'b0;
		clocks_c = 6'h00;
		class_c = bod_pkg::CLS_OTHER;
		case (op_r)
			bod_pkg::OP_JUMP_NO_OVERFLOW, bod_pkg::OP_JUMP_NOT_EQUAL,
			bod_pkg::OP_JUMP_EQUAL: begin
				class_c = bod_pkg::CLS_JCC;
				taken_c = jcc_taken; // RULE_01 RULE_02 RULE_03
				clocks_c = taken_c ? bod_pkg::CLK_JCC_TAKEN : bod_pkg::CLK_JCC_FALL;
			end
			bod_pkg::OP_LOOP_COUNT, bod_pkg::OP_LOOP_WHILE_EQUAL: begin
				class_c = bod_pkg::CLS_LOOP;
				taken_c = loop_taken; // RULE_04 RULE_05
				clocks_c = op_r == bod_pkg::OP_LOOP_COUNT
					? (taken_c ? bod_pkg::CLK_LOOP_TAKEN : bod_pkg::CLK_LOOP_FALL)
					: (taken_c ? bod_pkg::CLK_LOOP_WHILE_EQUAL_TAKEN : bod_pkg::CLK_LOOP_WHILE_EQUAL_FALL);
			end
			bod_pkg::OP_LEAVE_PROC: begin
				class_c = bod_pkg::CLS_LEAVE;
				clocks_c = bod_pkg::CLK_LEAVE; // RULE_06
			end
			bod_pkg::OP_INT_ON_OVERFLOW: begin
				class_c = bod_pkg::CLS_INTO;
				taken_c = flag_overflow; // RULE_07
				clocks_c = taken_c ? bod_pkg::CLK_INTO_TAKEN : bod_pkg::CLK_INTO_FALL;
			end
			bod_pkg::OP_INTERRUPT_RETURN: begin
				class_c = bod_pkg::CLS_INTERRUPT_RETURN_OP;
				taken_c = 1'b1;
				clocks_c = bod_pkg::CLK_INTERRUPT_RETURN_OP; // RULE_08
			end
			bod_pkg::OP_BUS_LOCK: begin
				class_c = bod_pkg::CLS_LOCK;
				clocks_c = bod_pkg::CLK_LOCK; // RULE_09
			end
			default: begin
				if (op_escape) begin
					class_c = bod_pkg::CLS_ESCAPE;
					clocks_c = bod_pkg::CLK_ESCAPE; // RULE_10
				end
			end
		endcase
	end

	// ==========================================================
	// Effective address and segment.
	wire direct = mod_f == bod_pkg::MOD_NO_DISP && rm_f == bod_pkg::RM_DIRECT;
	wire uses_frame = !direct && (rm_f == 3'h2 || rm_f == 3'h3 || rm_f == 3'h6);
	wire mem_operand = op_escape && mod_f != bod_pkg::MOD_REGISTER;
	logic [15:0] base_c;

	always_comb begin
		case (rm_f) // RULE_15
			3'h0: base_c = 16'(base_word_reg + source_index_reg);
			3'h1: base_c = 16'(base_word_reg + destination_index_reg);
			3'h2: base_c = 16'(frame_pointer_reg + source_index_reg);
			3'h3: base_c = 16'(frame_pointer_reg + destination_index_reg);
			3'h4: base_c = source_index_reg;
			3'h5: base_c = destination_index_reg;
			3'h6: base_c = frame_pointer_reg;
			default: base_c = base_word_reg;
		endcase
	end

	wire [15:0] ea_c = direct ? disp_r : 16'(base_c + disp_r); // RULE_16
	// The override is ignored for string destinations on purpose.
	wire [1:0] seg_c = string_dest_access ? bod_pkg::SEG_EXTRA // RULE_21
		: ovr_valid_r ? ovr_seg_r
		: uses_frame ? bod_pkg::SEG_STACK : bod_pkg::SEG_DATA; // RULE_20
	wire [3:0] reg_dec = reg_decode(reg_f, op_r[0]);
	wire [3:0] rm_dec = reg_decode(rm_f, op_r[0]);

	// ==========================================================
	// Result registers, loaded on the finishing cycle.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{done, count_write, sp_load_frame, int_request, ext_valid} <= 5'h0;
			{branch_taken, operand_is_reg, ea_valid, reg_high_byte, rm_high_byte} <= 5'h0;
			op_class <= bod_pkg::CLS_NONE;
			{op_code, op_clocks, ext_opcode, stack_pops} <= 22'h0;
			{branch_target, count_next, effective_address} <= 48'h0;
			ea_segment <= bod_pkg::SEG_DATA;
			{reg_index, rm_index} <= 6'h0;
		end else begin
			done <= fin;
			count_write <= fin && class_c == bod_pkg::CLS_LOOP; // RULE_04
			sp_load_frame <= fin && op_r == bod_pkg::OP_LEAVE_PROC; // RULE_06
			int_request <= fin && op_r == bod_pkg::OP_INT_ON_OVERFLOW && flag_overflow;
			ext_valid <= fin && op_escape; // RULE_10
			if (fin) begin
				op_class <= class_c;
				op_code <= op_r;
				op_clocks <= clocks_c;
				branch_taken <= taken_c;
				branch_target <= short_target;
				count_next <= cnt_dec;
				stack_pops <= op_r == bod_pkg::OP_LEAVE_PROC ? bod_pkg::POP_LEAVE
					: op_r == bod_pkg::OP_INTERRUPT_RETURN ? bod_pkg::POP_INTERRUPT_RETURN_OP : 2'h0;
				ext_opcode <= {op_r[2:0], reg_f};
				operand_is_reg <= op_escape && mod_f == bod_pkg::MOD_REGISTER; // RULE_11
				ea_valid <= mem_operand;
				effective_address <= ea_c;
				ea_segment <= seg_c;
				{reg_high_byte, reg_index} <= reg_dec;
				{rm_high_byte, rm_index} <= rm_dec;
			end
		end
	end

	assign byte_ready = ready_r;
	assign lock_active = lock_pend_r;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_disp8_modrm;
		state_r == bod_pkg::ST_MODRM && take && in_mod == bod_pkg::MOD_DISP8;
	endsequence
	sequence s_disp16_modrm;
		state_r == bod_pkg::ST_MODRM && take && in_mod == bod_pkg::MOD_DISP16;
	endsequence

	a_no_overflow_jump: assert property (fin && op_r == bod_pkg::OP_JUMP_NO_OVERFLOW |=> // RULE_01
		op_clocks == ($past(flag_overflow) ? 6'h04 : 6'h0d) && branch_taken == !$past(flag_overflow))
		else $error("no-overflow jump cost or decision wrong");
	a_not_equal_jump: assert property (fin && op_r == bod_pkg::OP_JUMP_NOT_EQUAL |=> // RULE_02
		branch_taken == !$past(flag_zero) && op_clocks == (branch_taken ? 6'h0d : 6'h04))
		else $error("not-equal jump wrong");
	a_equal_jump: assert property (fin && op_r == bod_pkg::OP_JUMP_EQUAL |=> // RULE_03
		branch_taken == $past(flag_zero) && op_clocks == (branch_taken ? 6'h0d : 6'h04))
		else $error("equal jump wrong");
	a_count_loop: assert property (fin && op_r == bod_pkg::OP_LOOP_COUNT |=> // RULE_04
		count_write && count_next == 16'($past(count_reg) - 16'h0001)
		&& branch_taken == (count_next != 16'h0000) && op_clocks == (branch_taken ? 6'h0f : 6'h05))
		else $error("count loop wrong");
	a_loop_equal: assert property (fin && op_r == bod_pkg::OP_LOOP_WHILE_EQUAL |=> // RULE_05
		branch_taken == (count_next != 16'h0000 && $past(flag_zero))
		&& op_clocks == (branch_taken ? 6'h10 : 6'h06))
		else $error("loop while equal wrong");
	a_leave_frame: assert property (fin && op_r == bod_pkg::OP_LEAVE_PROC |=> // RULE_06
		sp_load_frame && stack_pops == 2'h1 && op_clocks == 6'h08 ##1 !sp_load_frame)
		else $error("leave wrong");
	a_into_request: assert property (done |-> int_request == // RULE_07
		(op_code == bod_pkg::OP_INT_ON_OVERFLOW && op_clocks == 6'h30))
		else $error("overflow interrupt wrong");
	a_interrupt_return_op_pops: assert property (fin && op_r == bod_pkg::OP_INTERRUPT_RETURN |=> // RULE_08
		stack_pops == 2'h3 && op_clocks == 6'h1c)
		else $error("interrupt return wrong");
	a_lock_span: assert property (done && op_class == bod_pkg::CLS_LOCK |-> // RULE_09
		lock_active && op_clocks == 6'h02 ##1 (lock_active && !done))
		else $error("lock not held");
	a_disp8_fetch: assert property (s_disp8_modrm ##1 (take && !op_short) |=> // RULE_13
		state_r == bod_pkg::ST_FINISH && disp_r[15:8] == {8{disp_r[7]}})
		else $error("one-byte displacement wrong");
	a_disp16_fetch: assert property (s_disp16_modrm ##1 take |=> // RULE_14
		state_r == bod_pkg::ST_DISP_HI)
		else $error("two-byte displacement wrong");
	a_direct_addr: assert property (fin && mem_operand && direct |=> // RULE_16
		effective_address == $past(disp_r))
		else $error("direct address wrong");
	a_string_extra: assert property (fin && mem_operand && string_dest_access |=> // RULE_21
		ea_segment == 2'h0)
		else $error("string destination not in extra segment");
	a_frame_stack: assert property (fin && mem_operand && uses_frame // RULE_20
		&& !ovr_valid_r && !string_dest_access |=> ea_segment == 2'h2)
		else $error("frame pointer operand not in stack segment");

endmodule

`default_nettype wire

// *** tb/bod_decoder_bench.sv ***
`default_nettype none

module bod_decoder_bench;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [3:0] cls;
		logic [5:0] clk;
		logic tk;
		logic [15:0] tgt;
		logic [3:0] pul;
		logic [1:0] pops;
		logic [15:0] aux;
		logic [1:0] seg;
		logic [7:0] rd;
		logic [1:0] lck;
		logic mem;
		logic [7:0] opc;
	} bod_exp_t;

	logic clk_sys, reset_n, byte_valid, flag_zero, flag_overflow, string_dest_access;
	logic [7:0] byte_data;
	logic [15:0] byte_ip, base_word_reg, frame_pointer_reg, source_index_reg;
	logic [15:0] destination_index_reg, count_reg;
	logic byte_ready, done, branch_taken, count_write, sp_load_frame, int_request;
	logic lock_active, ext_valid, operand_is_reg, ea_valid, reg_high_byte, rm_high_byte;
	logic [3:0] op_class;
	logic [7:0] op_code;
	logic [5:0] op_clocks, ext_opcode;
	logic [15:0] branch_target, count_next, effective_address;
	logic [1:0] stack_pops, ea_segment;
	logic [2:0] reg_index, rm_index;
	logic [15:0] ip;
	logic [1:0] ovr;
	logic ov_en;
	int errors, checks_done, cycles, seed;
	bod_exp_t q[$];
	bod_exp_t e;
	logic [7:0] bops [5] = '{8'h71, 8'h74, 8'h75, 8'he2, 8'he1};

	bod_decoder u_dut (.clk_sys, .reset_n, .byte_valid, .byte_data, .byte_ip, .flag_zero,
		.flag_overflow, .base_word_reg, .frame_pointer_reg, .source_index_reg,
		.destination_index_reg, .count_reg, .string_dest_access, .byte_ready, .done, .op_class,
		.op_code, .op_clocks, .branch_taken, .branch_target, .count_next, .count_write,
		.sp_load_frame, .stack_pops, .int_request, .lock_active, .ext_valid, .ext_opcode,
		.operand_is_reg, .ea_valid, .effective_address, .ea_segment, .reg_index, .reg_high_byte,
		.rm_index, .rm_high_byte);

	always #25 clk_sys = ~clk_sys;

	// ==========================================================
	// Shared helpers.
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [15:0] sx(input logic [7:0] d);
		return {{8{d[7]}}, d};
	endfunction

	function automatic logic [3:0] rdec(input logic [2:0] f, input logic w);
		return w ? {1'b0, f} : {f[2], 1'b0, f[1:0]};
	endfunction

	// A byte is taken at the rising edge after a falling edge that saw byte_ready high.
	task automatic put(input logic [7:0] b);
		int n = 0;
		@(negedge clk_sys);
		byte_valid = 1'b1;
		byte_data = b;
		byte_ip = ip;
		while (byte_ready !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		ip = ip + 16'h0001;
	endtask

	// Flags and registers stay put until done, since they are sampled in the finishing cycle.
	task automatic fin();
		int n = 0;
		@(negedge clk_sys);
		byte_valid = 1'b0;
		byte_data = ~byte_data;
		while (q.size() != 0 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		if (q.size() != 0) begin
			errors++;
			$display("wrong value done expected 1 seen 0");
			q.delete();
		end
		ov_en = 1'b0;
	endtask

	task automatic rnd();
		base_word_reg = 16'($urandom);
		frame_pointer_reg = 16'($urandom);
		source_index_reg = 16'($urandom);
		destination_index_reg = 16'($urandom);
	endtask

	// ==========================================================
	// Scenario tasks.
	task automatic branch(input logic [7:0] op, input logic [7:0] d);
		bod_exp_t x = '0;
		logic [15:0] c = count_reg - 16'h0001;
		x.cls = op[7] ? 4'h2 : 4'h1;
		x.opc = op;
		x.tgt = ip + 16'h0002 + sx(d);
		x.aux = c;
		case (op)
			8'h71: x.tk = !flag_overflow;
			8'h74: x.tk = flag_zero;
			8'h75: x.tk = !flag_zero;
			8'he2: x.tk = c != 16'h0000;
			default: x.tk = c != 16'h0000 && flag_zero;
		endcase
		x.clk = op == 8'he2 ? (x.tk ? 6'h0f : 6'h05) :
			op == 8'he1 ? (x.tk ? 6'h10 : 6'h06) : (x.tk ? 6'h0d : 6'h04);
		x.pul = {op[7], 3'b000};
		q.push_back(x);
		put(op);
		put(d);
		fin();
	endtask

	task automatic one(input logic [7:0] op, input logic [1:0] lk);
		bod_exp_t x = '0;
		x.lck = lk;
		x.opc = op;
		x.cls = 4'h8;
		case (op)
			8'hce: begin
				x.cls = 4'h4;
				x.tk = flag_overflow;
				x.clk = flag_overflow ? 6'h30 : 6'h04;
				x.pul = {2'b00, flag_overflow, 1'b0};
			end
			8'hcf: {x.cls, x.tk, x.clk, x.pops} = {4'h5, 1'b1, 6'h1c, 2'h3};
			8'hc9: {x.cls, x.clk, x.pul, x.pops} = {4'h3, 6'h08, 4'h4, 2'h1};
			8'hf0: {x.cls, x.clk} = {4'h6, 6'h02};
			default: x.cls = 4'h8;
		endcase
		q.push_back(x);
		put(op);
		fin();
	endtask

	task automatic extension_escape(input logic [7:0] op, input logic [7:0] mr, input logic [15:0] d);
		bod_exp_t x = '0;
		logic [1:0] m = mr[7:6];
		logic [2:0] r = mr[2:0];
		logic dir = m == 2'h0 && r == 3'h6;
		logic bpb = r == 3'h2 || r == 3'h3 || (r == 3'h6 && !dir);
		case (r)
			3'h0: x.aux = base_word_reg + source_index_reg;
			3'h1: x.aux = base_word_reg + destination_index_reg;
			3'h2: x.aux = frame_pointer_reg + source_index_reg;
			3'h3: x.aux = frame_pointer_reg + destination_index_reg;
			3'h4: x.aux = source_index_reg;
			3'h5: x.aux = destination_index_reg;
			3'h6: x.aux = frame_pointer_reg;
			default: x.aux = base_word_reg;
		endcase
		x.aux = x.aux + (m == 2'h1 ? sx(d[7:0]) : m == 2'h2 ? d : 16'h0000);
		if (dir) x.aux = d;
		x.seg = string_dest_access ? 2'h0 : ov_en ? ovr : bpb ? 2'h2 : 2'h3;
		x.mem = m != 2'h3;
		{x.cls, x.clk, x.pul} = {4'h7, 6'h06, 4'h1};
		x.opc = op;
		x.tgt = {10'h000, op[2:0], mr[5:3]};
		x.rd = {rdec(mr[5:3], op[0]), rdec(r, op[0])};
		q.push_back(x);
		if (ov_en) put({3'h1, ovr, 3'h6});
		put(op);
		put(mr);
		if (m == 2'h1 || m == 2'h2 || dir) put(d[7:0]);
		if (m == 2'h2 || dir) put(d[15:8]);
		fin();
	endtask

	// ==========================================================
	// Result monitor: every done takes the oldest note off the queue.
	always @(negedge clk_sys) begin
		if (done === 1'b1) begin
			if (q.size() == 0) begin
				errors++;
				$display("wrong value done expected 0 seen 1");
			end else begin
				e = q.pop_front();
				check("op_class", op_class, e.cls);
				check("op_code", op_code, e.opc);
				check("op_clocks", op_clocks, e.clk);
				check("pulses", {count_write, sp_load_frame, int_request, ext_valid}, e.pul);
				check("stack_pops", stack_pops, e.pops);
				if (e.cls inside {4'h1, 4'h2, 4'h4, 4'h5}) check("branch_taken", branch_taken, e.tk);
				if (e.cls inside {4'h1, 4'h2}) check("branch_target", branch_target, e.tgt);
				if (e.cls == 4'h2) check("count_next", count_next, e.aux);
				if (e.lck[1]) check("lock_active", lock_active, e.lck[0]);
				if (e.cls == 4'h7) begin
					check("ext_opcode", ext_opcode, e.tgt);
					check("operand_kind", {operand_is_reg, ea_valid}, {!e.mem, e.mem});
					check("reg_rm_decode", {reg_high_byte, reg_index, rm_high_byte, rm_index}, e.rd);
					if (e.mem) check("effective_address", effective_address, e.aux);
					if (e.mem) check("ea_segment", ea_segment, e.seg);
				end
			end
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("wrong value cycle_limit expected %0d seen %0d", 19999, cycles);
			test_done();
		end
	end

	// ==========================================================
	// Main sequence.
	initial begin
		{clk_sys, reset_n, byte_valid, flag_zero, flag_overflow, string_dest_access} = '0;
		{byte_data, byte_ip, count_reg, ovr, ov_en, ip} = '0;
		{base_word_reg, frame_pointer_reg, source_index_reg, destination_index_reg} = '0;
		{errors, checks_done, cycles} = '0;
		seed = $urandom(61682);
		repeat (4) @(negedge clk_sys);
		check("reset_byte_ready", byte_ready, 1'b0);
		check("reset_ea_segment", ea_segment, 2'h3);
		reset_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		ip = 16'($urandom);
		for (int i = 0; i < 20; i++) begin
			{flag_overflow, flag_zero} = i[1:0];
			count_reg = i[1:0] == 2'h0 ? 16'h0001 : i[1:0] == 2'h1 ? 16'h0000 :
				i[1:0] == 2'h2 ? 16'h0002 : 16'($urandom);
			branch(bops[i / 4], i[1:0] == 2'h0 ? 8'h80 : i[1:0] == 2'h1 ? 8'h7f : 8'($urandom));
		end
		flag_overflow = 1'b0;
		one(8'hce, 2'b00);
		flag_overflow = 1'b1;
		one(8'hce, 2'b00);
		one(8'hcf, 2'b00);
		one(8'hf8, 2'b00);
		one(8'hf0, 2'b11);
		one(8'hc9, 2'b10);
		for (int i = 0; i < 40; i++) begin
			rnd();
			ov_en = i >= 32 || $urandom_range(0, 2) == 0;
			ovr = i >= 32 ? i[1:0] : 2'($urandom);
			string_dest_access = i < 32 && $urandom_range(0, 3) == 0;
			extension_escape({5'h1b, 3'($urandom)}, {i[4:3], 3'($urandom), i[2:0]}, 16'($urandom));
		end
		test_done();
	end
endmodule

`default_nettype wire
